// ==== brd_params.svh ====
// Purpose: constants for the branch, increment and or-literal decode block
// Assumes: 8-bit data path, 16-bit instruction words, 21-bit byte program counter
// Notes: definitions only, no logic
`ifndef BRD_PARAMS_SVH
`define BRD_PARAMS_SVH
// opcode fields
`define BRD_OP_JUMP 8'hef
`define BRD_OP_JUMP_WORD2 4'hf
`define BRD_OP_INC 6'h0a
`define BRD_OP_INC_SZ 6'h0f
`define BRD_OP_INC_SNZ 6'h12
`define BRD_OP_OR_LIT 8'h09
`define BRD_OP_MOVE_FF 4'hc
`define BRD_OP_LOAD_PTR 8'hee
// operand addressing
`define BRD_ILO_MAX 8'h5f
`define BRD_ACCESS_SPLIT 8'h80
`define BRD_ACCESS_HI_BANK 4'hf
`define BRD_ACCESS_LO_BANK 4'h0
// status field positions
`define BRD_ST_C 0
`define BRD_ST_DC 1
`define BRD_ST_Z 2
`define BRD_ST_OV 3
`define BRD_ST_N 4
// register offsets
`define BRD_REG_W 3'h0
`define BRD_REG_STATUS 3'h1
`define BRD_REG_BANK 3'h2
`define BRD_REG_CTRL 3'h3
`define BRD_REG_PC_L 3'h4
`define BRD_REG_PC_H 3'h5
`define BRD_REG_PC_U 3'h6
`define BRD_REG_STATE 3'h7
// reset values
`define BRD_RST_W 8'h00
`define BRD_RST_STATUS 5'h00
`define BRD_RST_BANK 4'h0
`define BRD_RST_PC 21'h000000
// program counter advance per word
`define BRD_PC_STEP 21'h000002
`endif

// ==== brd_pkg.sv ====
// Purpose: types shared by the decode block
// Assumes: nothing beyond the parameter header
// Notes: enums carry no explicit codes
package brd_pkg;
  // four clock phases of one instruction cycle
  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} brd_phase_t;
  // kind of the current instruction cycle
  typedef enum logic [1:0] {M_EXEC, M_JUMP_NOP, M_SKIP_NOP1, M_SKIP_NOP2} brd_mode_t;
  // decoded operation
  typedef enum logic [2:0] {
    OP_NONE, OP_JUMP, OP_INC, OP_INC_SZ, OP_INC_SNZ, OP_OR_LIT
  } brd_op_t;
endpackage : brd_pkg

// ==== brd_core.sv ====
// Purpose: decode and execute absolute jump, increments with skip, or-literal
// Assumes: fetch and data memory on clk_sys_in, one-cycle read latency each
// Notes: one instruction cycle is four clocks, phases Q1..Q4
// Function
// - jump target loads program counter bits 20:1
// - jump reaches whole program space, no paging
// - jump is two words, ef then f
// - jump takes two cycles, second one idle
// - increment adds one, writes destination
// - plain increment updates all five flags
// - destination bit picks accumulator or register
// - bank bit picks access or pointer bank
// - extended set, low offsets use indexed addressing
// - increment, skip next when result zero
// - increment, skip next when result nonzero
// - skip discards prefetch, runs one idle cycle
// - skipped two-word instruction costs another cycle
// - or literal into accumulator, N and Z
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "brd_params.svh"
module brd_core #(
  parameter int PC_W = 21,
  parameter int DADDR_W = 12
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // program fetch
  input wire logic [15:0] instr_in,
  output logic [PC_W-1:0] pc_out,
  // data memory
  input wire logic [7:0] dmem_rdata_in,
  input wire logic [DADDR_W-1:0] fsr2_in,
  output logic [DADDR_W-1:0] dmem_addr_out,
  output logic dmem_rd_out,
  output logic dmem_wr_out,
  output logic [7:0] dmem_wdata_out,
  // register port
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out
);
  // the jump literal is 20 bits landing at bit 1, so the counter must be 21 wide
  if (PC_W != 21) begin : g_bad_pc
    $error("brd_core: PC_W must be 21");
  end
  if (DADDR_W != 12) begin : g_bad_daddr
    $error("brd_core: DADDR_W must be 12");
  end

  // operation from the first instruction word
  function automatic brd_pkg::brd_op_t brd_decode(input logic [15:0] iw);
    if (iw[15:8] == `BRD_OP_JUMP) return brd_pkg::OP_JUMP;
    if (iw[15:10] == `BRD_OP_INC) return brd_pkg::OP_INC;
    if (iw[15:10] == `BRD_OP_INC_SZ) return brd_pkg::OP_INC_SZ;
    if (iw[15:10] == `BRD_OP_INC_SNZ) return brd_pkg::OP_INC_SNZ;
    if (iw[15:8] == `BRD_OP_OR_LIT) return brd_pkg::OP_OR_LIT;
    return brd_pkg::OP_NONE;
  endfunction : brd_decode

  // first words of the known two-word instructions
  function automatic logic brd_two_word(input logic [15:0] iw);
    return (iw[15:8] == `BRD_OP_JUMP) || (iw[15:12] == `BRD_OP_MOVE_FF) ||
           (iw[15:8] == `BRD_OP_LOAD_PTR);
  endfunction : brd_two_word

  // phase and mode state
  brd_pkg::brd_phase_t q_r; // phase of the current clock
  brd_pkg::brd_mode_t mode_r; // kind of the current instruction cycle
  brd_pkg::brd_op_t op_r; // latched operation
  logic [15:0] instr_r; // latched first word
  logic two_word_r; // discarded word starts a two-word instruction
  logic [7:0] jump_lo_r; // low target byte of a jump
  // architectural state
  logic [PC_W-1:0] pc_r;
  logic [7:0] w_r; // accumulator
  logic [4:0] status_r;
  logic [3:0] bank_r; // bank_pointer_register
  logic ext_en_r; // extended instruction set enable
  // data memory drive
  logic [DADDR_W-1:0] daddr_r;
  logic drd_r;
  logic dwr_r;
  logic [7:0] dwdata_r;
  logic [7:0] rdata_r;

  // result of the increment, valid at the q4 edge
  logic [7:0] inc_res;
  logic is_inc;
  logic do_skip;
  logic core_w_wr; // core writes the accumulator at this edge
  logic core_st_wr; // core writes status at this edge
  logic [DADDR_W-1:0] op_addr;
  logic [7:0] f_fld;

  assign f_fld = instr_r[7:0];
  assign inc_res = dmem_rdata_in + 8'h01;
  assign is_inc = (op_r == brd_pkg::OP_INC) || (op_r == brd_pkg::OP_INC_SZ) ||
                  (op_r == brd_pkg::OP_INC_SNZ);
  // skip on zero or nonzero result
  assign do_skip = (op_r == brd_pkg::OP_INC_SZ && inc_res == 8'h00) ||
                   (op_r == brd_pkg::OP_INC_SNZ && inc_res != 8'h00);
  assign core_w_wr = (q_r == brd_pkg::Q4) &&
                     ((is_inc && !instr_r[9]) || op_r == brd_pkg::OP_OR_LIT);
  assign core_st_wr = (q_r == brd_pkg::Q4) &&
                      (op_r == brd_pkg::OP_INC || op_r == brd_pkg::OP_OR_LIT);

  // operand address: indexed, access bank or pointer bank
  always_comb begin
    if (instr_r[8]) begin
      op_addr = {bank_r, f_fld};
    end else if (ext_en_r && f_fld <= `BRD_ILO_MAX) begin
      op_addr = fsr2_in + {4'h0, f_fld};
    end else if (f_fld < `BRD_ACCESS_SPLIT) begin
      op_addr = {`BRD_ACCESS_LO_BANK, f_fld};
    end else begin
      op_addr = {`BRD_ACCESS_HI_BANK, f_fld};
    end
  end

  // phase counter, free running from reset
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_r <= brd_pkg::Q1;
    end else begin
      unique case (q_r)
        brd_pkg::Q1: q_r <= brd_pkg::Q2;
        brd_pkg::Q2: q_r <= brd_pkg::Q3;
        brd_pkg::Q3: q_r <= brd_pkg::Q4;
        brd_pkg::Q4: q_r <= brd_pkg::Q1;
      endcase
    end
  end

  // cycle kind, decided at q4 for the next cycle
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_r <= brd_pkg::M_EXEC;
    end else if (q_r == brd_pkg::Q4) begin
      unique case (mode_r)
        brd_pkg::M_EXEC: begin
          if (op_r == brd_pkg::OP_JUMP) begin
            mode_r <= brd_pkg::M_JUMP_NOP;
          end else if (do_skip) begin
            mode_r <= brd_pkg::M_SKIP_NOP1;
          end
        end
        brd_pkg::M_SKIP_NOP1: begin
          // second word of the discarded instruction needs its own idle cycle
          mode_r <= two_word_r ? brd_pkg::M_SKIP_NOP2 : brd_pkg::M_EXEC;
        end
        brd_pkg::M_JUMP_NOP: mode_r <= brd_pkg::M_EXEC;
        brd_pkg::M_SKIP_NOP2: mode_r <= brd_pkg::M_EXEC;
      endcase
    end
  end

  // q1 decode; idle cycles decode nothing
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      op_r <= brd_pkg::OP_NONE;
      instr_r <= 16'h0000;
      two_word_r <= 1'b0;
    end else if (q_r == brd_pkg::Q1) begin
      if (mode_r == brd_pkg::M_EXEC) begin
        op_r <= brd_decode(instr_in);
        instr_r <= instr_in;
      end else begin
        op_r <= brd_pkg::OP_NONE;
      end
      // the prefetched word is looked at only to size the skip
      two_word_r <= (mode_r == brd_pkg::M_SKIP_NOP1) && brd_two_word(instr_in);
    end
  end

  // program counter: advance at q1, jump target at q4
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_r <= `BRD_RST_PC;
      jump_lo_r <= 8'h00;
    end else if (q_r == brd_pkg::Q1 && mode_r != brd_pkg::M_JUMP_NOP) begin
      // skip cycles step past the discarded words as well
      pc_r <= pc_r + `BRD_PC_STEP;
      jump_lo_r <= instr_in[7:0];
    end else if (q_r == brd_pkg::Q4 && op_r == brd_pkg::OP_JUMP) begin
      // second word is read now; no page bits, any even address is reachable
      pc_r <= {instr_in[11:0], jump_lo_r, 1'b0};
    end
  end

  // data memory read at q2, write strobe from q4
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      daddr_r <= 12'h000;
      drd_r <= 1'b0;
      dwr_r <= 1'b0;
      dwdata_r <= 8'h00;
    end else begin
      drd_r <= (q_r == brd_pkg::Q2) && is_inc;
      dwr_r <= (q_r == brd_pkg::Q4) && is_inc && instr_r[9];
      if (q_r == brd_pkg::Q2 && is_inc) begin
        daddr_r <= op_addr;
      end
      if (q_r == brd_pkg::Q4 && is_inc) begin
        dwdata_r <= inc_res;
      end
    end
  end

  // accumulator: core write wins over a software write at the same edge
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      w_r <= `BRD_RST_W;
    end else if (core_w_wr) begin
      if (op_r == brd_pkg::OP_OR_LIT) begin
        w_r <= w_r | instr_r[7:0];
      end else begin
        w_r <= inc_res;
      end
    end else if (reg_wr_in && reg_addr_in == `BRD_REG_W) begin
      w_r <= reg_wdata_in;
    end
  end

  // status flags; skip increments never touch them
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_r <= `BRD_RST_STATUS;
    end else if (core_st_wr && op_r == brd_pkg::OP_INC) begin
      status_r[`BRD_ST_C] <= (dmem_rdata_in == 8'hff);
      status_r[`BRD_ST_DC] <= (dmem_rdata_in[3:0] == 4'hf);
      status_r[`BRD_ST_Z] <= (inc_res == 8'h00);
      status_r[`BRD_ST_OV] <= (dmem_rdata_in == 8'h7f);
      status_r[`BRD_ST_N] <= inc_res[7];
    end else if (core_st_wr) begin
      status_r[`BRD_ST_Z] <= ((w_r | instr_r[7:0]) == 8'h00);
      status_r[`BRD_ST_N] <= w_r[7] | instr_r[7];
    end else if (reg_wr_in && reg_addr_in == `BRD_REG_STATUS) begin
      status_r <= reg_wdata_in[4:0];
    end
  end

  // software-only control registers
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bank_r <= `BRD_RST_BANK;
      ext_en_r <= 1'b0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `BRD_REG_BANK) begin
        bank_r <= reg_wdata_in[3:0];
      end
      if (reg_addr_in == `BRD_REG_CTRL) begin
        ext_en_r <= reg_wdata_in[0];
      end
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_r <= 8'h00;
    end else if (!reg_rd_in) begin
      rdata_r <= 8'h00;
    end else begin
      unique case (reg_addr_in)
        `BRD_REG_W: rdata_r <= w_r;
        `BRD_REG_STATUS: rdata_r <= {3'h0, status_r};
        `BRD_REG_BANK: rdata_r <= {4'h0, bank_r};
        `BRD_REG_CTRL: rdata_r <= {7'h00, ext_en_r};
        `BRD_REG_PC_L: rdata_r <= pc_r[7:0];
        `BRD_REG_PC_H: rdata_r <= pc_r[15:8];
        `BRD_REG_PC_U: rdata_r <= {3'h0, pc_r[20:16]};
        `BRD_REG_STATE: rdata_r <= {4'h0, mode_r, q_r};
      endcase
    end
  end

  // outputs straight from flops
  assign pc_out = pc_r;
  assign dmem_addr_out = daddr_r;
  assign dmem_rd_out = drd_r;
  assign dmem_wr_out = dwr_r;
  assign dmem_wdata_out = dwdata_r;
  assign reg_rdata_out = rdata_r;

  // checks on the design's own behaviour
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  // execution edges of each operation
  sequence s_q4_exec(brd_pkg::brd_op_t op);
    q_r == brd_pkg::Q4 && mode_r == brd_pkg::M_EXEC && op_r == op;
  endsequence
  sequence s_jump_idle;
    mode_r == brd_pkg::M_JUMP_NOP [*4] ##1 mode_r == brd_pkg::M_EXEC;
  endsequence

  property p_jump_target;
    s_q4_exec(brd_pkg::OP_JUMP) |=>
      pc_r == {$past(instr_in[11:0]), $past(jump_lo_r), 1'b0};
  endproperty
  a_jump_target: assert property (p_jump_target) else $error("jump target wrong");

  property p_jump_two_cycles;
    s_q4_exec(brd_pkg::OP_JUMP) |=> s_jump_idle ##0 op_r == brd_pkg::OP_NONE;
  endproperty
  a_jump_two_cycles: assert property (p_jump_two_cycles) else $error("jump cycles");

  property p_inc_write;
    s_q4_exec(brd_pkg::OP_INC) ##0 instr_r[9] |=>
      dmem_wr_out && dmem_wdata_out == $past(dmem_rdata_in) + 8'h01;
  endproperty
  a_inc_write: assert property (p_inc_write) else $error("increment write wrong");

  property p_inc_flags;
    s_q4_exec(brd_pkg::OP_INC) |=>
      status_r[`BRD_ST_Z] == ($past(dmem_rdata_in) == 8'hff) &&
      status_r[`BRD_ST_OV] == ($past(dmem_rdata_in) == 8'h7f);
  endproperty
  a_inc_flags: assert property (p_inc_flags) else $error("increment flags wrong");

  property p_to_accumulator;
    q_r == brd_pkg::Q4 && is_inc && !instr_r[9] |=>
      !dmem_wr_out && w_r == $past(dmem_rdata_in) + 8'h01;
  endproperty
  a_to_accumulator: assert property (p_to_accumulator) else $error("dest wrong");

  property p_indexed_addr;
    q_r == brd_pkg::Q2 && is_inc && !instr_r[8] && ext_en_r && instr_r[7:0] <= `BRD_ILO_MAX
      |=> dmem_addr_out == $past(fsr2_in) + {4'h0, $past(instr_r[7:0])} && dmem_rd_out;
  endproperty
  a_indexed_addr: assert property (p_indexed_addr) else $error("indexed addr wrong");

  property p_skip_zero;
    s_q4_exec(brd_pkg::OP_INC_SZ) ##0 dmem_rdata_in == 8'hff |=>
      mode_r == brd_pkg::M_SKIP_NOP1;
  endproperty
  a_skip_zero: assert property (p_skip_zero) else $error("skip on zero missed");

  property p_skip_nonzero;
    s_q4_exec(brd_pkg::OP_INC_SNZ) ##0 dmem_rdata_in != 8'hff |=>
      mode_r == brd_pkg::M_SKIP_NOP1;
  endproperty
  a_skip_nonzero: assert property (p_skip_nonzero) else $error("nz skip missed");

  property p_skip_discard;
    q_r == brd_pkg::Q1 && mode_r == brd_pkg::M_SKIP_NOP1 |=>
      op_r == brd_pkg::OP_NONE && pc_r == $past(pc_r) + `BRD_PC_STEP;
  endproperty
  a_skip_discard: assert property (p_skip_discard) else $error("no discard");

  property p_skip_two_word;
    q_r == brd_pkg::Q4 && mode_r == brd_pkg::M_SKIP_NOP1 && two_word_r |=>
      mode_r == brd_pkg::M_SKIP_NOP2;
  endproperty
  a_skip_two_word: assert property (p_skip_two_word) else $error("no second idle");

  property p_or_literal;
    s_q4_exec(brd_pkg::OP_OR_LIT) |=>
      w_r == ($past(w_r) | $past(instr_r[7:0])) && status_r[`BRD_ST_C] == $past(status_r[0]);
  endproperty
  a_or_literal: assert property (p_or_literal) else $error("or literal wrong");

  property p_skip_flags;
    q_r == brd_pkg::Q4 && (op_r == brd_pkg::OP_INC_SZ || op_r == brd_pkg::OP_INC_SNZ) &&
      !reg_wr_in |=> $stable(status_r);
  endproperty
  a_skip_flags: assert property (p_skip_flags) else $error("skip changed flags");
endmodule : brd_core

// ==== brd_mem_model.sv ====
// Purpose: program and data memory beside the decode block
// Assumes: one clock; program words alias on pc bits 8:1
// Notes: read data stand two clocks, then toggle each clock, so stale bytes match the old byte on alternate clocks
`timescale 1ns/1ps
module brd_mem_model (
  // clock
  input wire logic clk_sys_in,
  // program fetch
  input wire logic [20:0] pc_in,
  output logic [15:0] instr_out,
  // data memory
  input wire logic [11:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [15:0] pmem [0:255]; // program words, loaded by the bench
  logic [7:0] dmem [0:4095]; // data bytes, loaded and checked by the bench
  logic [1:0] hold_r; // clocks that read data still stand
  initial begin
    instr_out = 16'h0000;
    rdata_out = 8'h00;
    hold_r = 2'h0;
  end
  // fetch one clock behind pc, well before the next q1 edge
  always @(posedge clk_sys_in) begin
    instr_out <= pmem[pc_in[8:1]];
  end
  // answer a read next clock, hold one more, then go stale
  always @(posedge clk_sys_in) begin
    if (rd_in) begin
      rdata_out <= dmem[addr_in];
      hold_r <= 2'h1;
    end else if (hold_r != 2'h0) begin
      hold_r <= hold_r - 2'h1;
    end else begin
      rdata_out <= ~rdata_out; // no hold owed: invert each clock, the old byte returns every other clock
    end
  end
  // plain behavioural memory so the bench may poke it by hierarchy
  always @(posedge clk_sys_in) begin
    if (wr_in) begin
      dmem[addr_in] <= wdata_in;
    end
  end
endmodule : brd_mem_model

// ==== tb_top.sv ====
// Purpose: self-checking bench for jump, increments with skip, or-literal
// Assumes: programs start at word 3; words 0..2 idle while registers load
// Notes: edge k is the k-th rising edge after reset release, q1 when k%4==0
`timescale 1ns/1ps
`include "brd_params.svh"
module tb_top;
  logic clk_sys_in = 1'b0; // system clock, 50 ns
  logic rst_n_in = 1'b0; // async reset, low active
  logic [15:0] instr; // fetched word
  logic [20:0] pc; // fetch address
  logic [7:0] dmem_rdata;
  logic [11:0] fsr2 = 12'h000; // index pointer
  logic [11:0] dmem_addr;
  logic dmem_rd;
  logic dmem_wr;
  logic [7:0] dmem_wdata;
  logic [2:0] reg_addr = 3'h0; // register port, driven on rising edges
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  int fail_count = 0;
  int tests_run = 0;
  int edge_cnt = 0; // edges since release
  // clock
  always #25 clk_sys_in = ~clk_sys_in;
  // edge counter, restarts with every reset
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) edge_cnt <= 0;
    else edge_cnt <= edge_cnt + 1;
  end
  brd_core #(.PC_W(21), .DADDR_W(12)) uut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .instr_in(instr), .pc_out(pc),
    .dmem_rdata_in(dmem_rdata), .fsr2_in(fsr2), .dmem_addr_out(dmem_addr),
    .dmem_rd_out(dmem_rd), .dmem_wr_out(dmem_wr), .dmem_wdata_out(dmem_wdata),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata)
  );
  brd_mem_model mdl (
    .clk_sys_in(clk_sys_in), .pc_in(pc), .instr_out(instr), .addr_in(dmem_addr),
    .rd_in(dmem_rd), .wr_in(dmem_wr), .wdata_in(dmem_wdata), .rdata_out(dmem_rdata)
  );
  // verdict, the only exit
  task automatic end_of_test();
    $display("checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  // compare with four-state equality
  task automatic check(input logic [20:0] seen, input logic [20:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // return in the active region of edge k, before that edge's updates
  task automatic at_edge(input int k);
    int n;
    for (n = 0; n < 400; n++) begin
      @(posedge clk_sys_in);
      if (edge_cnt == k) return;
    end
    fail_count++;
    $display("mismatch at %0t: edge %0d never reached", $time, k);
    end_of_test();
  endtask : at_edge
  task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr <= 1'b0;
  endtask : reg_write
  // data stand only in the cycle after the strobe
  task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read
  // clear program, then reset for five clocks
  task automatic prog_clear();
    int i;
    rst_n_in <= 1'b0;
    for (i = 0; i < 256; i++) mdl.pmem[i] = 16'h0000;
  endtask : prog_clear
  task automatic boot();
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
  endtask : boot
  // one plain increment at word 3, operand through bank, access or index
  task automatic inc_case(input logic d, input logic a, input logic [7:0] f, bnk, ctl,
      input logic [11:0] fs, addr, input logic [7:0] val, em, ew, es);
    logic [7:0] r;
    prog_clear();
    mdl.pmem[3] = {`BRD_OP_INC, d, a, f};
    mdl.dmem[addr] = val;
    fsr2 <= fs;
    boot();
    reg_write(`BRD_REG_BANK, bnk);
    reg_write(`BRD_REG_CTRL, ctl);
    at_edge(14);
    check(dmem_rd, 1'b1);
    check(dmem_addr, addr);
    at_edge(16);
    check(dmem_wr, d);
    at_edge(20);
    check(mdl.dmem[addr], em);
    reg_read(`BRD_REG_W, r);
    check(r, ew);
    reg_read(`BRD_REG_STATUS, r);
    check(r, es);
  endtask : inc_case
  // skip increment at word 3 on 0x140, then a one- or two-word victim
  task automatic skip_case(input logic [5:0] op, input logic [7:0] val,
      input logic skip, input logic two);
    logic [7:0] r;
    prog_clear();
    mdl.pmem[3] = {op, 1'b1, 1'b1, 8'h40};
    mdl.pmem[4] = two ? 16'hc123 : {`BRD_OP_OR_LIT, 8'h01};
    mdl.pmem[5] = two ? 16'hf456 : {`BRD_OP_OR_LIT, 8'h04};
    mdl.pmem[6] = two ? {`BRD_OP_OR_LIT, 8'h04} : 16'h0000;
    mdl.dmem[12'h140] = val;
    boot();
    reg_write(`BRD_REG_BANK, 8'h01);
    at_edge(16);
    reg_read(`BRD_REG_STATE, r);
    check(r[3:2], skip ? brd_pkg::M_SKIP_NOP1 : brd_pkg::M_EXEC);
    if (two) begin
      at_edge(20);
      reg_read(`BRD_REG_STATE, r);
      check(r[3:2], brd_pkg::M_SKIP_NOP2);
    end
    at_edge(36);
    check(mdl.dmem[12'h140], 8'(val + 8'h01));
    reg_read(`BRD_REG_W, r);
    check(r, skip ? 8'h04 : 8'h05);
    reg_read(`BRD_REG_STATUS, r);
    check(r, 8'h00);
  endtask : skip_case
  // jump at word 3; word 5 would spoil w if it ran
  task automatic jump_case(input logic [19:0] t);
    logic [7:0] r;
    prog_clear();
    mdl.pmem[3] = {`BRD_OP_JUMP, t[7:0]};
    mdl.pmem[4] = {`BRD_OP_JUMP_WORD2, t[19:8]};
    mdl.pmem[5] = {`BRD_OP_OR_LIT, 8'h01};
    mdl.pmem[t[7:0]] = {`BRD_OP_OR_LIT, 8'h5a};
    boot();
    at_edge(16);
    check(pc, {t, 1'b0});
    reg_read(`BRD_REG_STATE, r);
    check(r[3:2], brd_pkg::M_JUMP_NOP);
    at_edge(28);
    reg_read(`BRD_REG_W, r);
    check(r, 8'h5a);
  endtask : jump_case
  // or literal with c, dc, ov preset so only n and z may move
  task automatic or_case(input logic [7:0] w0, k, ew, es);
    logic [7:0] r;
    prog_clear();
    mdl.pmem[3] = {`BRD_OP_OR_LIT, k};
    boot();
    reg_write(`BRD_REG_W, w0);
    reg_write(`BRD_REG_STATUS, 8'h0b);
    at_edge(20);
    reg_read(`BRD_REG_W, r);
    check(r, ew);
    reg_read(`BRD_REG_STATUS, r);
    check(r, es);
  endtask : or_case
  // main sequence
  initial begin
    inc_case(1'b1, 1'b1, 8'h7f, 8'h03, 8'h00, 12'h000, 12'h37f, 8'h7f, 8'h80, 8'h00, 8'h1a);
    inc_case(1'b0, 1'b1, 8'hff, 8'h03, 8'h00, 12'h000, 12'h3ff, 8'hff, 8'hff, 8'h00, 8'h07);
    inc_case(1'b1, 1'b0, 8'h90, 8'h03, 8'h00, 12'h000, 12'hf90, 8'h0f, 8'h10, 8'h00, 8'h02);
    inc_case(1'b1, 1'b0, 8'h5f, 8'h03, 8'h01, 12'h200, 12'h25f, 8'h00, 8'h01, 8'h00, 8'h00);
    inc_case(1'b1, 1'b0, 8'h90, 8'h03, 8'h01, 12'h200, 12'hf90, 8'h10, 8'h11, 8'h00, 8'h00);
    inc_case(1'b1, 1'b0, 8'h20, 8'h03, 8'h00, 12'h000, 12'h020, 8'h3f, 8'h40, 8'h00, 8'h02);
    inc_case(1'b0, 1'b1, 8'h10, 8'h03, 8'h01, 12'h200, 12'h310, 8'h41, 8'h41, 8'h42, 8'h00);
    skip_case(`BRD_OP_INC_SZ, 8'hff, 1'b1, 1'b0);
    skip_case(`BRD_OP_INC_SZ, 8'hff, 1'b1, 1'b1);
    skip_case(`BRD_OP_INC_SZ, 8'h05, 1'b0, 1'b0);
    skip_case(`BRD_OP_INC_SNZ, 8'h05, 1'b1, 1'b0);
    skip_case(`BRD_OP_INC_SNZ, 8'h05, 1'b1, 1'b1);
    skip_case(`BRD_OP_INC_SNZ, 8'hff, 1'b0, 1'b0);
    jump_case(20'h12345);
    jump_case(20'hfffff);
    or_case(8'h80, 8'h00, 8'h80, 8'h1b);
    or_case(8'h00, 8'h00, 8'h00, 8'h0f);
    or_case(8'h12, 8'h21, 8'h33, 8'h0b);
    end_of_test();
  end
endmodule : tb_top
